// file: rtl/ald_decode_top.sv
// Overview of operation
// - Add direct: two bytes, one cycle
// - Add indirect: one byte, one cycle
// - Add-carry register sums A, Rn, carry
// - Add-carry immediate: two bytes, one cycle
// - Add-carry direct: two bytes, one cycle
// - Add-carry indirect: one byte, one cycle
// - Subtract-borrow register: A minus Rn, carry
// - Subtract-borrow direct: two bytes, one cycle
// - Subtract-borrow indirect: one byte, one cycle
// - Subtract-borrow immediate: two bytes, one cycle
// - AND immediate into direct: 3 bytes, 2 cycles
// - OR immediate into direct: 3 bytes, 2 cycles
// - XOR immediate into direct: 3 bytes, 2 cycles
// - XOR direct into A: two bytes, one cycle
// - XOR indirect into A: one byte, one cycle
// - AND direct into A: two bytes, one cycle
// - AND indirect into A: one byte, one cycle
// - Rotate left through carry, nine bits
// - Rotate right through carry, nine bits
// - Indirect address comes from R0 or R1
// - Branch offset is signed, added to PC
// - Standard opcode encodings and semantics
module ald_decode_top (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Fetch side
   input wire logic fetch_valid,
   input wire logic [7:0] fetch_byte,
   output logic fetch_ready,
   // Internal data memory
   output logic [7:0] mem_addr,
   output logic mem_rd,
   input wire logic [7:0] mem_rdata,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   // Register loads from the rest of the core
   input wire logic aux_wr,
   input wire logic [7:0] aux_wdata,
   input wire logic bank_wr,
   input wire logic [2:0] bank_idx,
   input wire logic [7:0] bank_wdata,
   // Relative branch target
   input wire logic [15:0] pc_in,
   input wire logic [7:0] rel_in,
   output logic [15:0] branch_target,
   // Core state
   output logic [7:0] acc,
   output logic [7:0] aux,
   output logic carry,
   output logic [15:0] data_pointer,
   output logic instr_done,
   output logic instr_illegal,
   output logic busy
);

   ald_pkg::ald_state_t state_q;
   ald_pkg::ald_state_t state_d;
   logic [7:0] opc_q;
   logic [7:0] op1_q;
   logic [7:0] op2_q;
   logic [7:0] mdat_q;
   logic [7:0] acc_q;
   logic [7:0] acc_d;
   logic [7:0] aux_q;
   logic [7:0] aux_d;
   logic carry_q;
   logic carry_d;
   logic [15:0] data_pointer_q;
   logic [15:0] data_pointer_d;
   logic [15:0] target_q;
   logic done_q;
   logic illegal_q;
   logic [1:0] len_q;
   logic [2:0] cyc_q;
   logic [1:0] nbytes_q;
   logic [2:0] ncyc_q;
   logic [7:0] bank_q [ald_pkg::BANK_SIZE];

   ald_alu_if alu_bus ();

   ald_alu u_alu (
      .port_i (alu_bus.alu)
   );

   // Opcode classification shared by length, time and execute decode
   function automatic logic fam_ok(input logic [7:0] o);
      logic [3:0] hi;
      logic [3:0] lo;
      logic arith;
      logic logic_fam;
      hi = o[ald_pkg::HI_MSB:ald_pkg::HI_LSB];
      lo = o[ald_pkg::LO_MSB:0];
      arith = (hi == ald_pkg::FAM_ADD) || (hi == ald_pkg::FAM_ADD_WITH_CARRY) || (hi == ald_pkg::FAM_SUBTRACT_WITH_BORROW);
      logic_fam = (hi == ald_pkg::FAM_OR) || (hi == ald_pkg::FAM_AND) || (hi == ald_pkg::FAM_XOR);
      return (arith && (lo >= ald_pkg::LO_IMM)) || (logic_fam && (lo >= ald_pkg::LO_DIR_A));
   endfunction

   function automatic logic [1:0] len_of(input logic [7:0] o);
      logic [3:0] lo;
      lo = o[ald_pkg::LO_MSB:0];
      if (!fam_ok(o) || o[ald_pkg::LO_REG_BIT] || lo == ald_pkg::LO_IND0 || lo == ald_pkg::LO_IND1)
         return ald_pkg::LEN_ONE;
      else if (lo == ald_pkg::LO_DIR_IMM)
         return ald_pkg::LEN_THREE;
      else
         return ald_pkg::LEN_TWO;
   endfunction

   function automatic logic [2:0] cyc_of(input logic [7:0] o);
      if (fam_ok(o) && o[ald_pkg::LO_MSB:0] == ald_pkg::LO_DIR_IMM)
         return ald_pkg::CYC_TWO;
      else if (o == ald_pkg::OPC_INC_DATA_POINTER)
         return ald_pkg::CYC_TWO;
      else if (o == ald_pkg::OPC_MUL || o == ald_pkg::OPC_DIV)
         return ald_pkg::CYC_FOUR;
      else
         return ald_pkg::CYC_ONE;
   endfunction

   // Execute decode
   logic [3:0] hi;
   logic [3:0] lo;
   logic fam;
   logic src_reg;
   logic src_imm;
   logic src_dir;
   logic src_ind;
   logic dst_dir_a;
   logic dst_dir_imm;
   logic dst_dir;
   logic is_muldiv;
   logic is_inc_data_pointer;
   logic is_single;
   logic known;
   logic use_carry;
   logic wr_carry;
   logic take;
   logic exec;
   logic first_cyc;
   logic last_cyc;
   logic commit;
   logic [7:0] rn_val;
   logic [7:0] ptr_val;
   logic [7:0] mem_opnd;

   assign hi = opc_q[ald_pkg::HI_MSB:ald_pkg::HI_LSB];
   assign lo = opc_q[ald_pkg::LO_MSB:0];
   assign fam = fam_ok(opc_q);
   assign src_reg = fam && opc_q[ald_pkg::LO_REG_BIT];
   assign src_imm = fam && lo == ald_pkg::LO_IMM;
   assign src_dir = fam && lo == ald_pkg::LO_DIR;
   assign src_ind = fam && (lo == ald_pkg::LO_IND0 || lo == ald_pkg::LO_IND1);
   assign dst_dir_a = fam && lo == ald_pkg::LO_DIR_A;
   assign dst_dir_imm = fam && lo == ald_pkg::LO_DIR_IMM;
   assign dst_dir = dst_dir_a || dst_dir_imm;
   assign is_muldiv = opc_q == ald_pkg::OPC_MUL || opc_q == ald_pkg::OPC_DIV;
   assign is_inc_data_pointer = opc_q == ald_pkg::OPC_INC_DATA_POINTER;
   assign is_single = is_muldiv || is_inc_data_pointer || opc_q == ald_pkg::OPC_RLC
      || opc_q == ald_pkg::OPC_RRC || opc_q == ald_pkg::OPC_RL || opc_q == ald_pkg::OPC_RR
      || opc_q == ald_pkg::OPC_CLR_A || opc_q == ald_pkg::OPC_CPL_A
      || opc_q == ald_pkg::OPC_SWAP_A || opc_q == ald_pkg::OPC_INC_A
      || opc_q == ald_pkg::OPC_DEC_A;
   assign known = fam || is_single;
   assign use_carry = (fam && (hi == ald_pkg::FAM_ADD_WITH_CARRY || hi == ald_pkg::FAM_SUBTRACT_WITH_BORROW))
      || opc_q == ald_pkg::OPC_RLC || opc_q == ald_pkg::OPC_RRC;
   assign wr_carry = (fam && (hi == ald_pkg::FAM_ADD || use_carry)) || use_carry || is_muldiv;

   assign take = fetch_valid && fetch_ready;
   assign exec = state_q == ald_pkg::ST_EXECUTE;
   assign first_cyc = ncyc_q == 3'h0;
   assign last_cyc = ncyc_q == 3'(cyc_q - ald_pkg::CYC_ONE);
   assign commit = exec && last_cyc;

   // Indirect operand always addressed by R0 or R1 from the opcode low bit
   assign rn_val = bank_q[opc_q[2:0]];
   assign ptr_val = bank_q[{2'h0, opc_q[ald_pkg::LO_PTR_BIT]}];
   assign mem_opnd = first_cyc ? mem_rdata : mdat_q;

   // Memory port: read in the first cycle, write back in the last
   assign mem_addr = src_ind ? ptr_val : op1_q;
   assign mem_rd = exec && first_cyc && (src_dir || src_ind || dst_dir);
   assign mem_wr = commit && dst_dir;
   assign mem_wdata = alu_bus.res;

   // Operand selection
   assign alu_bus.a = dst_dir ? mem_opnd : acc_q;
   assign alu_bus.b = src_reg ? rn_val
      : src_imm ? op1_q
      : dst_dir_imm ? op2_q
      : dst_dir_a ? acc_q
      : is_muldiv ? aux_q
      : mem_opnd;
   assign alu_bus.cin = use_carry ? carry_q : 1'b0;

   always_comb
   begin
      alu_bus.op = ald_pkg::ALU_PASS;
      if (fam)
      begin
         unique case (hi)
            ald_pkg::FAM_ADD: alu_bus.op = ald_pkg::ALU_ADD;
            ald_pkg::FAM_ADD_WITH_CARRY: alu_bus.op = ald_pkg::ALU_ADD;
            ald_pkg::FAM_SUBTRACT_WITH_BORROW: alu_bus.op = ald_pkg::ALU_SUB;
            ald_pkg::FAM_OR: alu_bus.op = ald_pkg::ALU_OR;
            ald_pkg::FAM_AND: alu_bus.op = ald_pkg::ALU_AND;
            ald_pkg::FAM_XOR: alu_bus.op = ald_pkg::ALU_XOR;
         endcase
      end
      else
      begin
         unique case (opc_q)
            ald_pkg::OPC_RLC: alu_bus.op = ald_pkg::ALU_RLC;
            ald_pkg::OPC_RRC: alu_bus.op = ald_pkg::ALU_RRC;
            ald_pkg::OPC_RL: alu_bus.op = ald_pkg::ALU_RL;
            ald_pkg::OPC_RR: alu_bus.op = ald_pkg::ALU_RR;
            ald_pkg::OPC_MUL: alu_bus.op = ald_pkg::ALU_MUL;
            ald_pkg::OPC_DIV: alu_bus.op = ald_pkg::ALU_DIV;
            ald_pkg::OPC_CLR_A: alu_bus.op = ald_pkg::ALU_CLR;
            ald_pkg::OPC_CPL_A: alu_bus.op = ald_pkg::ALU_CPL;
            ald_pkg::OPC_SWAP_A: alu_bus.op = ald_pkg::ALU_SWAP;
            ald_pkg::OPC_INC_A: alu_bus.op = ald_pkg::ALU_INC;
            ald_pkg::OPC_DEC_A: alu_bus.op = ald_pkg::ALU_DEC;
            default: alu_bus.op = ald_pkg::ALU_PASS;
         endcase
      end
   end

   // Sequencer: opcode, operand bytes, then the instruction cycles
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ald_pkg::ST_OPCODE:
            if (take)
               state_d = (len_of(fetch_byte) == ald_pkg::LEN_ONE) ? ald_pkg::ST_EXECUTE
                  : ald_pkg::ST_OPERAND;
         ald_pkg::ST_OPERAND:
            if (take && 2'(nbytes_q + 2'h1) == len_q)
               state_d = ald_pkg::ST_EXECUTE;
         ald_pkg::ST_EXECUTE:
            if (last_cyc)
               state_d = ald_pkg::ST_OPCODE;
      endcase
   end

   assign fetch_ready = state_q != ald_pkg::ST_EXECUTE;

   // Next architectural state
   assign acc_d = (commit && known && !dst_dir && !is_inc_data_pointer) ? alu_bus.res : acc_q;
   assign carry_d = (commit && wr_carry) ? alu_bus.cout : carry_q;
   assign aux_d = (commit && is_muldiv) ? alu_bus.res_hi : aux_wr ? aux_wdata : aux_q;
   assign data_pointer_d = (commit && is_inc_data_pointer) ? data_pointer_q + ald_pkg::DATA_POINTER_STEP : data_pointer_q;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_q <= ald_pkg::ST_OPCODE;
         nbytes_q <= 2'h0;
         ncyc_q <= 3'h0;
      end
      else
      begin
         state_q <= state_d;
         if (take)
            nbytes_q <= (state_q == ald_pkg::ST_OPCODE) ? ald_pkg::LEN_ONE : 2'(nbytes_q + 2'h1);
         if (take && state_q == ald_pkg::ST_OPCODE)
            ncyc_q <= 3'h0;
         else if (exec && !last_cyc)
            ncyc_q <= 3'(ncyc_q + 3'h1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         opc_q <= ald_pkg::BYTE_ZERO;
         len_q <= ald_pkg::LEN_ONE;
         cyc_q <= ald_pkg::CYC_ONE;
      end
      else if (take && state_q == ald_pkg::ST_OPCODE)
      begin
         opc_q <= fetch_byte;
         len_q <= len_of(fetch_byte);
         cyc_q <= cyc_of(fetch_byte);
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         op1_q <= ald_pkg::BYTE_ZERO;
         op2_q <= ald_pkg::BYTE_ZERO;
      end
      else if (take && state_q == ald_pkg::ST_OPERAND)
      begin
         if (nbytes_q == ald_pkg::LEN_ONE)
            op1_q <= fetch_byte;
         else
            op2_q <= fetch_byte;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         acc_q <= ald_pkg::BYTE_ZERO;
         aux_q <= ald_pkg::BYTE_ZERO;
         carry_q <= 1'b0;
         data_pointer_q <= ald_pkg::DATA_POINTER_RESET;
         mdat_q <= ald_pkg::BYTE_ZERO;
         done_q <= 1'b0;
         illegal_q <= 1'b0;
         target_q <= ald_pkg::DATA_POINTER_RESET;
      end
      else
      begin
         acc_q <= acc_d;
         aux_q <= aux_d;
         carry_q <= carry_d;
         data_pointer_q <= data_pointer_d;
         if (mem_rd)
            mdat_q <= mem_rdata;
         done_q <= commit;
         illegal_q <= commit && !known;
         target_q <= pc_in + {{8{rel_in[7]}}, rel_in};
      end
   end

   // Register bank entries
   for (genvar i = 0; i < ald_pkg::BANK_SIZE; i++)
   begin : g_bank
      always_ff @(posedge clk)
      begin
         if (srst)
            bank_q[i] <= ald_pkg::BYTE_ZERO;
         else if (bank_wr && bank_idx == 3'(i))
            bank_q[i] <= bank_wdata;
      end
   end

   assign acc = acc_q;
   assign aux = aux_q;
   assign carry = carry_q;
   assign data_pointer = data_pointer_q;
   assign branch_target = target_q;
   assign instr_done = done_q;
   assign instr_illegal = illegal_q;
   assign busy = state_q != ald_pkg::ST_OPCODE;

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   AST_ADD_DIR_SIZE:
      assert property (commit && opc_q == 8'h25 |-> nbytes_q == 2'h2 && ncyc_q == 3'h0)
         else $error("add direct size or time wrong");

   AST_IND_ONE_BYTE:
      assert property (commit && src_ind |-> nbytes_q == 2'h1 && ncyc_q == 3'h0)
         else $error("indirect form size or time wrong");

   AST_ADD_WITH_CARRY_REG_SUM:
      assert property (commit && fam && hi == ald_pkg::FAM_ADD_WITH_CARRY && src_reg
         |=> {carry_q, acc_q} == 9'($past(acc_q)) + 9'($past(rn_val)) + 9'($past(carry_q)))
         else $error("add with carry register sum wrong");

   AST_IMM_TWO_BYTES:
      assert property (commit && src_imm |-> nbytes_q == 2'h2 && ncyc_q == 3'h0)
         else $error("immediate form size or time wrong");

   AST_SUBTRACT_WITH_BORROW_REG_DIFF:
      assert property (commit && fam && hi == ald_pkg::FAM_SUBTRACT_WITH_BORROW && src_reg
         |=> acc_q == 8'($past(acc_q) - $past(rn_val) - 8'($past(carry_q))))
         else $error("subtract with borrow register result wrong");

   AST_DIR_SRC_SIZE:
      assert property (commit && src_dir |-> nbytes_q == 2'h2 && ncyc_q == 3'h0)
         else $error("direct source size or time wrong");

   AST_DIR_IMM_WRITE:
      assert property (take && state_q == ald_pkg::ST_OPCODE
         && fetch_byte inside {8'h53, 8'h43, 8'h63}
         |-> ##[3:40] (mem_wr && nbytes_q == 2'h3 && ncyc_q == 3'h1 && mem_addr == op1_q))
         else $error("logic immediate to direct not written in 3 bytes, 2 cycles");

   AST_IND_PTR_ADDR:
      assert property (mem_rd && src_ind |-> mem_addr == bank_q[{2'h0, opc_q[0]}])
         else $error("indirect address not from R0 or R1");

   AST_RLC_NINE_BIT:
      assert property (commit && opc_q == ald_pkg::OPC_RLC
         |=> acc_q == {$past(acc_q[6:0]), $past(carry_q)} && carry_q == $past(acc_q[7]))
         else $error("rotate left through carry wrong");

   AST_RRC_NINE_BIT:
      assert property (commit && opc_q == ald_pkg::OPC_RRC
         |=> acc_q == {$past(carry_q), $past(acc_q[7:1])} && carry_q == $past(acc_q[0]))
         else $error("rotate right through carry wrong");

   AST_BRANCH_SIGNED:
      assert property (1'b1 |=> branch_target == 16'($past(pc_in) + {{8{$past(rel_in[7])}},
         $past(rel_in)}))
         else $error("relative branch target wrong");

   AST_MULDIV_FOUR:
      assert property (commit && is_muldiv |-> nbytes_q == 2'h1 && ncyc_q == 3'h3
         && $past(exec, 3))
         else $error("multiply or divide not four cycles");

   AST_DATA_POINTER_INC:
      assert property (commit && is_inc_data_pointer |-> ncyc_q == 3'h1 ##1 data_pointer
         == 16'($past(data_pointer_q) + 16'h0001))
         else $error("data pointer increment wrong");

endmodule // ald_decode_top

// file: rtl/ald_pkg.sv
package ald_pkg;

   // Core clock period
   localparam int unsigned CLK_PERIOD_NS = 10;

   // Register bank
   localparam int unsigned BANK_SIZE = 8;
   localparam logic [2:0] BANK_IDX_W = 3'h3;

   // Opcode fields
   localparam int unsigned HI_MSB = 7;
   localparam int unsigned HI_LSB = 4;
   localparam int unsigned LO_MSB = 3;
   localparam int unsigned LO_REG_BIT = 3;
   localparam int unsigned LO_PTR_BIT = 0;

   // Operation families (high nibble)
   localparam logic [3:0] FAM_ADD = 4'h2;
   localparam logic [3:0] FAM_ADD_WITH_CARRY = 4'h3;
   localparam logic [3:0] FAM_SUBTRACT_WITH_BORROW = 4'h9;
   localparam logic [3:0] FAM_OR = 4'h4;
   localparam logic [3:0] FAM_AND = 4'h5;
   localparam logic [3:0] FAM_XOR = 4'h6;

   // Operand modes (low nibble)
   localparam logic [3:0] LO_DIR_A = 4'h2;
   localparam logic [3:0] LO_DIR_IMM = 4'h3;
   localparam logic [3:0] LO_IMM = 4'h4;
   localparam logic [3:0] LO_DIR = 4'h5;
   localparam logic [3:0] LO_IND0 = 4'h6;
   localparam logic [3:0] LO_IND1 = 4'h7;

   // Single opcodes
   localparam logic [7:0] OPC_RLC = 8'h33;
   localparam logic [7:0] OPC_RRC = 8'h13;
   localparam logic [7:0] OPC_RL = 8'h23;
   localparam logic [7:0] OPC_RR = 8'h03;
   localparam logic [7:0] OPC_INC_DATA_POINTER = 8'ha3;
   localparam logic [7:0] OPC_MUL = 8'ha4;
   localparam logic [7:0] OPC_DIV = 8'h84;
   localparam logic [7:0] OPC_CLR_A = 8'he4;
   localparam logic [7:0] OPC_CPL_A = 8'hf4;
   localparam logic [7:0] OPC_SWAP_A = 8'hc4;
   localparam logic [7:0] OPC_INC_A = 8'h04;
   localparam logic [7:0] OPC_DEC_A = 8'h14;

   // Lengths in bytes and times in instruction cycles (one clock each)
   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;
   localparam logic [2:0] CYC_ONE = 3'h1;
   localparam logic [2:0] CYC_TWO = 3'h2;
   localparam logic [2:0] CYC_FOUR = 3'h4;

   // Reset values and steps
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [7:0] BYTE_ALL = 8'hff;
   localparam logic [15:0] DATA_POINTER_RESET = 16'h0000;
   localparam logic [15:0] DATA_POINTER_STEP = 16'h0001;

   typedef enum logic [4:0] {
      ALU_PASS, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_RLC, ALU_RRC,
      ALU_RL, ALU_RR, ALU_MUL, ALU_DIV, ALU_CLR, ALU_CPL, ALU_SWAP, ALU_INC, ALU_DEC
   } ald_alu_op_t;

   typedef enum logic [1:0] {ST_OPCODE, ST_OPERAND, ST_EXECUTE} ald_state_t;

endpackage // ald_pkg

// file: rtl/ald_alu_if.sv
interface ald_alu_if;
   logic [7:0] a;
   logic [7:0] b;
   logic cin;
   ald_pkg::ald_alu_op_t op;
   logic [7:0] res;
   logic [7:0] res_hi;
   logic cout;
   logic ov;

   modport ctl (output a, output b, output cin, output op,
                input res, input res_hi, input cout, input ov);
   modport alu (input a, input b, input cin, input op,
                output res, output res_hi, output cout, output ov);
endinterface // ald_alu_if

// file: rtl/ald_alu.sv
module ald_alu (
   // Operands and result
   ald_alu_if.alu port_i
);

   logic [8:0] sum9;
   logic [8:0] diff9;
   logic [15:0] prod;

   assign sum9 = {1'b0, port_i.a} + {1'b0, port_i.b} + {8'h00, port_i.cin};
   assign diff9 = {1'b0, port_i.a} - {1'b0, port_i.b} - {8'h00, port_i.cin};
   assign prod = {8'h00, port_i.a} * {8'h00, port_i.b};

   always_comb
   begin
      port_i.res = port_i.a;
      port_i.res_hi = ald_pkg::BYTE_ZERO;
      port_i.cout = port_i.cin;
      port_i.ov = 1'b0;
      unique case (port_i.op)
         ald_pkg::ALU_ADD:
         begin
            port_i.res = sum9[7:0];
            port_i.cout = sum9[8];
            port_i.ov = (port_i.a[7] == port_i.b[7]) && (sum9[7] != port_i.a[7]);
         end
         ald_pkg::ALU_SUB:
         begin
            port_i.res = diff9[7:0];
            port_i.cout = diff9[8];
            port_i.ov = (port_i.a[7] != port_i.b[7]) && (diff9[7] != port_i.a[7]);
         end
         ald_pkg::ALU_AND: port_i.res = port_i.a & port_i.b;
         ald_pkg::ALU_OR: port_i.res = port_i.a | port_i.b;
         ald_pkg::ALU_XOR: port_i.res = port_i.a ^ port_i.b;
         ald_pkg::ALU_RLC:
         begin
            port_i.res = {port_i.a[6:0], port_i.cin};
            port_i.cout = port_i.a[7];
         end
         ald_pkg::ALU_RRC:
         begin
            port_i.res = {port_i.cin, port_i.a[7:1]};
            port_i.cout = port_i.a[0];
         end
         ald_pkg::ALU_RL: port_i.res = {port_i.a[6:0], port_i.a[7]};
         ald_pkg::ALU_RR: port_i.res = {port_i.a[0], port_i.a[7:1]};
         ald_pkg::ALU_MUL:
         begin
            port_i.res = prod[7:0];
            port_i.res_hi = prod[15:8];
            port_i.cout = 1'b0;
            port_i.ov = |prod[15:8];
         end
         ald_pkg::ALU_DIV:
         begin
            port_i.cout = 1'b0;
            port_i.ov = (port_i.b == ald_pkg::BYTE_ZERO);
            port_i.res = port_i.ov ? ald_pkg::BYTE_ALL : port_i.a / port_i.b;
            port_i.res_hi = port_i.ov ? ald_pkg::BYTE_ALL : port_i.a % port_i.b;
         end
         ald_pkg::ALU_CLR: port_i.res = ald_pkg::BYTE_ZERO;
         ald_pkg::ALU_CPL: port_i.res = ~port_i.a;
         ald_pkg::ALU_SWAP: port_i.res = {port_i.a[3:0], port_i.a[7:4]};
         ald_pkg::ALU_INC: port_i.res = port_i.a + ald_pkg::BYTE_ONE;
         ald_pkg::ALU_DEC: port_i.res = port_i.a - ald_pkg::BYTE_ONE;
         default: port_i.res = port_i.a;
      endcase
   end

endmodule // ald_alu

// file: test/ald_mem_model.sv
module ald_mem_model (
   // Clock
   input wire logic clk,
   // Data memory port
   input wire logic [7:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [256];
   // Each byte starts out holding its own address
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 8'(i);
   end
   // Valid only under a read strobe, inverted otherwise
   assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
   always @(posedge clk)
      if (mem_wr)
         mem[mem_addr] <= mem_wdata;
endmodule // ald_mem_model

// file: test/ald_arith_logic_instr_decode_bench.sv
module ald_arith_logic_instr_decode_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, srst, fetch_valid, fetch_ready, aux_wr, bank_wr, mem_rd, mem_wr;
   logic carry, instr_done, instr_illegal, busy;
   logic [7:0] fetch_byte, mem_addr, mem_rdata, mem_wdata, aux_wdata, bank_wdata;
   logic [7:0] rel_in, acc, aux;
   logic [2:0] bank_idx;
   logic [15:0] pc_in, branch_target, data_pointer;
   int error_cnt, comparisons, ticks;

   ald_decode_top u_ald_decode_top (.clk(clk), .srst(srst), .fetch_valid(fetch_valid),
      .fetch_byte(fetch_byte), .fetch_ready(fetch_ready), .mem_addr(mem_addr),
      .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
      .aux_wr(aux_wr), .aux_wdata(aux_wdata), .bank_wr(bank_wr), .bank_idx(bank_idx),
      .bank_wdata(bank_wdata), .pc_in(pc_in), .rel_in(rel_in),
      .branch_target(branch_target), .acc(acc), .aux(aux), .carry(carry),
      .data_pointer(data_pointer), .instr_done(instr_done),
      .instr_illegal(instr_illegal), .busy(busy));
   ald_mem_model u_ald_mem_model (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task close_out();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Cuts a hang short
   always @(posedge clk)
   begin
      ticks++;
      if (ticks == 3000)
      begin
         error_cnt++;
         close_out();
      end
   end

   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Loads a bank register or the auxiliary register
   task setr(input logic b, input logic [2:0] i, input logic [7:0] d);
      bank_wr = b;
      aux_wr = !b;
      bank_idx = i;
      bank_wdata = d;
      aux_wdata = d;
      @(negedge clk);
      bank_wr = 1'b0;
      aux_wr = 1'b0;
   endtask

   // Feeds one instruction, counts execute cycles, checks acc and carry
   task op(input logic [7:0] b0, b1, b2, input logic [1:0] len, input logic [2:0] cyc,
           input logic [7:0] ea, input logic ec);
      logic [7:0] b [3];
      int n;
      b = '{b0, b1, b2};
      n = 0;
      fetch_valid = 1'b1;
      for (int i = 0; i < len; i++)
      begin
         fetch_byte = b[i];
         @(negedge clk);
      end
      fetch_valid = 1'b0;
      while (instr_done !== 1'b1 && n < 20)
      begin
         n += (fetch_ready === 1'b0);
         @(negedge clk);
      end
      chk("cycles", 16'(n), {13'h0000, cyc});
      chk("illegal", instr_illegal, 16'h0000);
      chk("busy", busy, 16'h0000);
      chk("acc", acc, ea);
      chk("carry", carry, ec);
   endtask

   // An opcode outside the handled set runs as a one-cycle no-op and is flagged
   task t_illegal();
      fetch_valid = 1'b1;
      fetch_byte = 8'ha5;
      @(negedge clk);
      fetch_valid = 1'b0;
      @(negedge clk);
      chk("illegal", instr_illegal, 16'h0001);
      chk("illegal_acc", acc, 16'h0010);
      $display("t_illegal finished");
   endtask

   task t_add();
      setr(1'b1, 3'h0, 8'h20);
      setr(1'b1, 3'h1, 8'h21);
      setr(1'b1, 3'h2, 8'h03);
      setr(1'b1, 3'h3, 8'h05);
      op(8'h24, 8'hff, 8'h00, 2'h2, 3'h1, 8'hff, 1'b0);
      op(8'h25, 8'h01, 8'h00, 2'h2, 3'h1, 8'h00, 1'b1);
      op(8'h3b, 8'h00, 8'h00, 2'h1, 3'h1, 8'h06, 1'b0);
      op(8'h26, 8'h00, 8'h00, 2'h1, 3'h1, 8'h26, 1'b0);
      op(8'h34, 8'he0, 8'h00, 2'h2, 3'h1, 8'h06, 1'b1);
      op(8'h35, 8'h10, 8'h00, 2'h2, 3'h1, 8'h17, 1'b0);
      op(8'h37, 8'h00, 8'h00, 2'h1, 3'h1, 8'h38, 1'b0);
      $display("t_add finished");
   endtask

   task t_subtract_with_borrow();
      op(8'h9a, 8'h00, 8'h00, 2'h1, 3'h1, 8'h35, 1'b0);
      op(8'h94, 8'h40, 8'h00, 2'h2, 3'h1, 8'hf5, 1'b1);
      op(8'h95, 8'h10, 8'h00, 2'h2, 3'h1, 8'he4, 1'b0);
      op(8'h96, 8'h00, 8'h00, 2'h1, 3'h1, 8'hc4, 1'b0);
      $display("t_subtract_with_borrow finished");
   endtask

   task t_rot_logic();
      op(8'h33, 8'h00, 8'h00, 2'h1, 3'h1, 8'h88, 1'b1);
      op(8'h13, 8'h00, 8'h00, 2'h1, 3'h1, 8'hc4, 1'b0);
      op(8'h55, 8'h0f, 8'h00, 2'h2, 3'h1, 8'h04, 1'b0);
      op(8'h65, 8'h21, 8'h00, 2'h2, 3'h1, 8'h25, 1'b0);
      op(8'h67, 8'h00, 8'h00, 2'h1, 3'h1, 8'h04, 1'b0);
      op(8'h56, 8'h00, 8'h00, 2'h1, 3'h1, 8'h00, 1'b0);
      $display("t_rot_logic finished");
   endtask

   task t_mem_logic();
      op(8'h53, 8'h5a, 8'h0f, 2'h3, 3'h2, 8'h00, 1'b0);
      op(8'h43, 8'h5b, 8'ha0, 2'h3, 3'h2, 8'h00, 1'b0);
      op(8'h63, 8'h5c, 8'hff, 2'h3, 3'h2, 8'h00, 1'b0);
      chk("and_byte", u_ald_mem_model.mem[8'h5a], 16'h000a);
      chk("or_byte", u_ald_mem_model.mem[8'h5b], 16'h00fb);
      chk("xor_byte", u_ald_mem_model.mem[8'h5c], 16'h00a3);
      $display("t_mem_logic finished");
   endtask

   task t_muldiv();
      setr(1'b0, 3'h0, 8'h07);
      op(8'h24, 8'h0c, 8'h00, 2'h2, 3'h1, 8'h0c, 1'b0);
      op(8'ha4, 8'h00, 8'h00, 2'h1, 3'h4, 8'h54, 1'b0);
      chk("aux", aux, 16'h0000);
      setr(1'b0, 3'h0, 8'h05);
      op(8'h84, 8'h00, 8'h00, 2'h1, 3'h4, 8'h10, 1'b0);
      chk("aux", aux, 16'h0004);
      $display("t_muldiv finished");
   endtask

   task t_data_pointer_branch();
      repeat (256) op(8'ha3, 8'h00, 8'h00, 2'h1, 3'h2, 8'h10, 1'b0);
      chk("data_pointer", data_pointer, 16'h0100);
      pc_in = 16'h1000;
      rel_in = 8'h80;
      @(negedge clk);
      @(negedge clk);
      chk("branch_target", branch_target, 16'h0f80);
      $display("t_data_pointer_branch finished");
   endtask

   initial
   begin
      srst = 1'b1;
      fetch_valid = 1'b0;
      fetch_byte = 8'h00;
      {aux_wr, bank_wr, aux_wdata, bank_wdata, bank_idx} = '0;
      pc_in = 16'h0000;
      rel_in = 8'h00;
      repeat (12) @(negedge clk);
      srst = 1'b0;
      t_add();
      t_subtract_with_borrow();
      t_rot_logic();
      t_mem_logic();
      t_muldiv();
      t_data_pointer_branch();
      t_illegal();
      close_out();
   end
endmodule // ald_arith_logic_instr_decode_bench
